/* File: logic/scfg_defs.svh */
// Purpose: offsets, reset values and field positions of the synthesizer config slice
// Assumes: 16-bit registers on a 32-bit APB data path
// Notes: offsets are register indices; byte address is four times the index
`ifndef SCFG_DEFS_SVH
`define SCFG_DEFS_SVH

`define SCFG_IDX_CTRL 4'h0
`define SCFG_IDX_PINCAL 4'h1
`define SCFG_IDX_RSV2 4'h2
`define SCFG_IDX_RSV3 4'h3
`define SCFG_IDX_RSV4 4'h4
`define SCFG_IDX_RSV5 4'h5
`define SCFG_IDX_RSV6 4'h6
`define SCFG_IDX_RSV7 4'h7
`define SCFG_IDX_STATUS 4'h8
`define SCFG_NUM_WORDS 8

`define SCFG_RST_CTRL 16'h0004
`define SCFG_RST_PINCAL 16'h080C
`define SCFG_RST_RSV2 16'h0500
`define SCFG_RST_RSV3 16'h0642
`define SCFG_RST_RSV4 16'h0A43
`define SCFG_RST_RSV5 16'h00C8
`define SCFG_RST_RSV6 16'hC802
`define SCFG_RST_RSV7 16'h00B2

`define SCFG_REQ_PINCAL_HI 12'h080
`define SCFG_REQ_RSV4 16'h0E43
`define SCFG_REQ_RSV5 16'h03E8
`define SCFG_REQ_RSV6 16'h7802

`define SCFG_BIT_REGRESET 1
`define SCFG_BIT_FUNCSEL 2
`define SCFG_BIT_PINDRIVE 3
`define SCFG_DIV_MSB 2
`define SCFG_DIV_LSB 0
`define SCFG_HI_MSB 15
`define SCFG_HI_LSB 4

`define SCFG_ZERO16 16'h0000
`define SCFG_ZERO32 32'h0000_0000

`endif

/* File: logic/scfg_pkg.sv */
// Purpose: shared types of the synthesizer config slice
// Assumes: included header supplies the numbers
// Notes: types only
package scfg_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic write;
    logic [31:0] wdata;
  } scfg_req_s;
  typedef logic [15:0] scfg_word_t;
endpackage

/* File: logic/scfg_word_file.sv */
// Purpose: eight 16-bit configuration words with per-word reset values
// Assumes: one write port, one registered read port
// Notes: soft clear restores every word to its default
`timescale 1ns/100ps
`include "scfg_defs.svh"
module scfg_word_file (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // soft register reset
  input wire logic soft_clr,
  // write port
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire scfg_pkg::scfg_word_t wr_data,
  // read port
  input wire logic [2:0] rd_idx,
  output scfg_pkg::scfg_word_t rd_data,
  // live word of index one
  output scfg_pkg::scfg_word_t pincal_word
);
  localparam logic [15:0] RST_VALS [0:7] = '{`SCFG_RST_CTRL, `SCFG_RST_PINCAL, `SCFG_RST_RSV2,
    `SCFG_RST_RSV3, `SCFG_RST_RSV4, `SCFG_RST_RSV5, `SCFG_RST_RSV6, `SCFG_RST_RSV7};
  scfg_pkg::scfg_word_t word_reg [0:7];
  scfg_pkg::scfg_word_t rd_data_reg;

  // one word per entry; word 0 is unused here but kept so indices match offsets
  genvar gi;
  generate
    for (gi = 0; gi < `SCFG_NUM_WORDS; gi = gi + 1) begin : g_word
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          word_reg[gi] <= RST_VALS[gi];
        end else if (soft_clr) begin
          word_reg[gi] <= RST_VALS[gi];
        end else if (wr_en && wr_idx == 3'(gi)) begin
          word_reg[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // read data comes from a register so the bus sees a stable value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_reg <= `SCFG_ZERO16;
    end else begin
      rd_data_reg <= word_reg[rd_idx];
    end
  end

  assign rd_data = rd_data_reg;
  assign pincal_word = word_reg[1];
endmodule

/* File: logic/scfg_cal_clk_div.sv */
// Purpose: calibration state-machine clock enable from the reference clock
// Assumes: reference clock is CLK; output is a one-cycle tick per divided period
// Notes: divide by two to the power of the field; field 0 ticks every cycle
`timescale 1ns/100ps
module scfg_cal_clk_div (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ratio exponent
  input wire logic [2:0] div_exp,
  // outputs
  output logic sm_tick,
  output logic sm_clk_level
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] last_val;
  logic sm_tick_reg;
  logic sm_lvl_reg;

  // terminal count is 2^n - 1
  assign last_val = 8'((9'h001 << div_exp) - 9'h001);
  assign cnt_next = (cnt_reg >= last_val) ? 8'h00 : 8'(cnt_reg + 8'h01);

  // a shrinking ratio restarts at zero rather than running past the terminal count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 8'h00;
      sm_tick_reg <= 1'b0;
      sm_lvl_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      sm_tick_reg <= (cnt_reg >= last_val);
      sm_lvl_reg <= (div_exp == 3'h0) ? ~sm_lvl_reg : (cnt_next < (last_val >> 1) + 8'h01);
    end
  end

  assign sm_tick = sm_tick_reg;
  assign sm_clk_level = sm_lvl_reg;
endmodule

/* File: logic/scfg_regs.sv */
// Purpose: APB register slice, words 0 to 7, status word 8, status pin drive and calibration clock divider
// Assumes: APB slave, zero wait states, 16-bit words in the low half of the data bus
// Notes: byte address is four times the word index; other addresses read zero, ignore writes
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`include "scfg_defs.svh"
module scfg_regs (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // status sources
  input wire logic LOCK_IN,
  input wire logic READBACK_IN,
  // multiplexed status pin
  output logic STATUS_PIN_O,
  output logic STATUS_PIN_OE,
  // calibration clock
  output logic SM_TICK,
  output logic SM_CLK,
  // programming health, set when words 4 to 6 hold their required values and the word 1 upper-field error flag is clear
  output logic RSV_PROGRAMMED
);
  scfg_pkg::scfg_req_s req;
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic lock_meta_reg;
  logic lock_sync_reg;
  logic rb_meta_reg;
  logic rb_sync_reg;
  logic pin_o_reg;
  logic pin_oe_reg;
  logic hi_err_reg;
  logic hi_err_next;
  scfg_pkg::scfg_word_t file_rd;
  scfg_pkg::scfg_word_t pincal;
  logic [31:0] prdata_reg;

  // request bundle and address decode
  assign req = '{addr: PADDR, write: PWRITE, wdata: PWDATA};
  wire [13:0] word_idx = req.addr[15:2];
  wire aligned = (req.addr[1:0] == 2'b00);
  wire hit_ctrl = aligned && (word_idx == 14'(`SCFG_IDX_CTRL));
  wire hit_file = aligned && (word_idx >= 14'(`SCFG_IDX_PINCAL)) && (word_idx <= 14'(`SCFG_IDX_RSV7));
  wire hit_status = aligned && (word_idx == 14'(`SCFG_IDX_STATUS));
  wire mapped = hit_ctrl || hit_file || hit_status;
  wire access = PSEL && PENABLE;
  wire setup = PSEL && !PENABLE;
  wire wr_ctrl = access && req.write && hit_ctrl;
  wire wr_file = access && req.write && hit_file;
  wire soft_rst = ctrl_reg[`SCFG_BIT_REGRESET];

  // word 0 holds only reset and function select in this slice
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = `SCFG_ZERO16;
      ctrl_next[`SCFG_BIT_REGRESET] = req.wdata[`SCFG_BIT_REGRESET];
      ctrl_next[`SCFG_BIT_FUNCSEL] = req.wdata[`SCFG_BIT_FUNCSEL];
    end else if (soft_rst) begin
      ctrl_next[`SCFG_BIT_FUNCSEL] = 1'(`SCFG_RST_CTRL >> `SCFG_BIT_FUNCSEL);
    end
  end

  // the reset bit itself stays set until software clears it, so the slice is held meanwhile
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= `SCFG_RST_CTRL;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // words 1 to 7 with per-word defaults
  scfg_word_file u_words (
    .clk(CLK),
    .resetn(RESETN),
    .soft_clr(soft_rst),
    .wr_en(wr_file),
    .wr_idx(word_idx[2:0]),
    .wr_data(req.wdata[15:0]),
    .rd_idx(word_idx[2:0]),
    .rd_data(file_rd),
    .pincal_word(pincal)
  );

  // divider counter keeps running while the soft reset bit is set; only its tick and clock outputs are gated low
  wire div_rstn = RESETN;
  logic sm_tick_raw;
  logic sm_lvl_raw;
  scfg_cal_clk_div u_div (
    .clk(CLK),
    .resetn(div_rstn),
    .div_exp(pincal[`SCFG_DIV_MSB:`SCFG_DIV_LSB]),
    .sm_tick(sm_tick_raw),
    .sm_clk_level(sm_lvl_raw)
  );
  assign SM_TICK = sm_tick_raw && !soft_rst;
  assign SM_CLK = sm_lvl_raw && !soft_rst;

  // external status sources are asynchronous; two flops before use
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
      rb_meta_reg <= 1'b0;
      rb_sync_reg <= 1'b0;
    end else begin
      lock_meta_reg <= LOCK_IN;
      lock_sync_reg <= lock_meta_reg;
      rb_meta_reg <= READBACK_IN;
      rb_sync_reg <= rb_meta_reg;
    end
  end

  // pin source and drive, registered so the pad sees glitch-free levels
  wire pin_src = ctrl_reg[`SCFG_BIT_FUNCSEL] ? lock_sync_reg : rb_sync_reg;
  wire pin_drive = pincal[`SCFG_BIT_PINDRIVE];
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_o_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_o_reg <= pin_src;
      pin_oe_reg <= pin_drive;
    end
  end
  assign STATUS_PIN_O = pin_o_reg;
  assign STATUS_PIN_OE = pin_oe_reg;

  // flags a word 1 write whose upper field is not the required constant; software's duty, shown only
  assign hi_err_next = wr_file && (word_idx[2:0] == 3'(`SCFG_IDX_PINCAL))
    ? (req.wdata[`SCFG_HI_MSB:`SCFG_HI_LSB] != `SCFG_REQ_PINCAL_HI) : hi_err_reg;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hi_err_reg <= 1'b0;
    end else if (soft_rst) begin
      hi_err_reg <= 1'b0;
    end else begin
      hi_err_reg <= hi_err_next;
    end
  end

  // reserved words compare against the values software must load before normal use
  logic rsv4_ok;
  logic rsv5_ok;
  logic rsv6_ok;
  logic [15:0] shadow4_reg;
  logic [15:0] shadow5_reg;
  logic [15:0] shadow6_reg;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      shadow4_reg <= `SCFG_RST_RSV4;
      shadow5_reg <= `SCFG_RST_RSV5;
      shadow6_reg <= `SCFG_RST_RSV6;
    end else if (soft_rst) begin
      shadow4_reg <= `SCFG_RST_RSV4;
      shadow5_reg <= `SCFG_RST_RSV5;
      shadow6_reg <= `SCFG_RST_RSV6;
    end else if (wr_file) begin
      if (word_idx[2:0] == 3'(`SCFG_IDX_RSV4)) begin
        shadow4_reg <= req.wdata[15:0];
      end else if (word_idx[2:0] == 3'(`SCFG_IDX_RSV5)) begin
        shadow5_reg <= req.wdata[15:0];
      end else if (word_idx[2:0] == 3'(`SCFG_IDX_RSV6)) begin
        shadow6_reg <= req.wdata[15:0];
      end
    end
  end
  assign rsv4_ok = (shadow4_reg == `SCFG_REQ_RSV4);
  assign rsv5_ok = (shadow5_reg == `SCFG_REQ_RSV5);
  assign rsv6_ok = (shadow6_reg == `SCFG_REQ_RSV6);
  assign RSV_PROGRAMMED = rsv4_ok && rsv5_ok && rsv6_ok && !hi_err_reg;

  // read data is captured in the setup cycle so it is valid during the access phase
  wire [31:0] status_word = {28'h0000000, hi_err_reg, rsv6_ok, rsv5_ok, rsv4_ok};
  wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_reg} : hit_status ? status_word : `SCFG_ZERO32;
  logic sel_file_reg;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_reg <= `SCFG_ZERO32;
      sel_file_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= rd_mux;
      sel_file_reg <= hit_file;
    end
  end

  // word file output is already registered from the setup-cycle address
  assign PRDATA = sel_file_reg ? {16'h0000, file_rd} : prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;

  // status pin floats whenever the drive bit is clear
  pin_float_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !$past(pincal[`SCFG_BIT_PINDRIVE]) |-> !STATUS_PIN_OE) else $error("status pin driven while disabled");

  // pin carries lock when function select is set
  pin_lock_a: assert property (@(posedge CLK) disable iff (!RESETN)
    $past(ctrl_reg[`SCFG_BIT_FUNCSEL]) |-> STATUS_PIN_O == $past(lock_sync_reg))
    else $error("status pin not lock");

  // soft reset returns word 4 to its default
  soft_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
    soft_rst |=> (shadow4_reg == `SCFG_RST_RSV4)) else $error("word 4 not restored");

  // a write to word 5 lands in its shadow on the next cycle
  word_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_file && word_idx[2:0] == 3'(`SCFG_IDX_RSV5) && !soft_rst) |=> shadow5_reg == $past(req.wdata[15:0]))
    else $error("word 5 write lost");

  // with field 1, tick spacing is two: a tick is never followed by another
  tick_rate_a: assert property (@(posedge CLK) disable iff (!RESETN || soft_rst)
    (pincal[2:0] == 3'h1 && $stable(pincal) && sm_tick_raw) |=> !sm_tick_raw)
    else $error("divide by two ticks too often");

  // loading the required word 4 value is recognised on the next cycle
  req_val_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (wr_file && word_idx[2:0] == 3'(`SCFG_IDX_RSV4) && req.wdata[15:0] == `SCFG_REQ_RSV4 && !soft_rst)
    |=> rsv4_ok) else $error("word 4 required value not recognised");

  // the word 6 shadow must track the stored word, or the health flag lies
  req_six_a: assert property (@(posedge CLK) disable iff (!RESETN)
    shadow6_reg == u_words.word_reg[6]) else $error("word 6 shadow out of step");

  // unmapped access reports an error
  bad_addr_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (access && !mapped) |-> PSLVERR && PREADY) else $error("unmapped access not flagged");
endmodule

/* File: test/scfg_regs_tb_top.sv */
// Purpose: self-checking bench for the config word slice, its status pin and calibration tick
// Assumes: zero wait state APB slave; byte address is four times the word index
// Notes: random data from a fixed seed; expected values come from the bench tables only
`timescale 1ns/100ps
`include "scfg_defs.svh"
module scfg_regs_tb_top;
  logic CLK, RESETN, PSEL, PENABLE, PWRITE, LOCK_IN, READBACK_IN;
  logic [15:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic PREADY, PSLVERR, STATUS_PIN_O, STATUS_PIN_OE, SM_TICK, SM_CLK, RSV_PROGRAMMED;
  integer failures = 0;
  integer check_count = 0;
  integer seed = 6817;
  integer cycles = 0;
  integer ticks, highs, i, d;
  logic [31:0] rd;
  logic err, bit_a, bit_b;
  logic [15:0] wval [1:7];

  scfg_regs scfg_regs_i (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LOCK_IN(LOCK_IN), .READBACK_IN(READBACK_IN), .STATUS_PIN_O(STATUS_PIN_O),
    .STATUS_PIN_OE(STATUS_PIN_OE), .SM_TICK(SM_TICK), .SM_CLK(SM_CLK), .RSV_PROGRAMMED(RSV_PROGRAMMED));

  // free running 100 MHz clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // power-on defaults of each word, kept apart from the design on purpose
  function automatic logic [15:0] dflt(input integer idx);
    case (idx)
      0: dflt = 16'h0004;
      1: dflt = 16'h080C;
      2: dflt = 16'h0500;
      3: dflt = 16'h0642;
      4: dflt = 16'h0A43;
      5: dflt = 16'h00C8;
      6: dflt = 16'hC802;
      default: dflt = 16'h00B2;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count = check_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wd);
    integer n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= addr;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 50) begin
      n = n + 1;
      @(posedge CLK);
    end
    if (n == 50) chk(32'h0000_0000, 32'h0000_0001, "pready never came");
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd_word(input integer idx, input logic [15:0] exp, input string what);
    apb(1'b0, 16'(idx * 4), 32'h0000_0000);
    chk(rd, {16'h0000, exp}, what);
  endtask

  // a hang ends in the same closing report
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      failures = failures + 1;
      $display("Error at %0t: run took too long", $time);
      tally_and_finish();
    end
  end

  initial begin
    RESETN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 16'h0000;
    PWDATA = 32'h0000_0000;
    LOCK_IN = 1'b0;
    READBACK_IN = 1'b0;
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    // defaults of every word straight after reset
    for (i = 0; i < 8; i = i + 1) rd_word(i, dflt(i), "reset value");
    chk({31'h0, STATUS_PIN_OE}, 32'h0000_0001, "pin drive after reset");
    $display("test reset_values done");
    // random words written back to back, then read back
    for (i = 1; i < 8; i = i + 1) begin
      wval[i] = 16'($random(seed));
      // word 1 keeps its required upper field and a divider that is never zero
      if (i == 1) wval[1] = {12'h080, wval[1][3:0] | 4'h1};
      apb(1'b1, 16'(i * 4), {16'h0000, wval[i]});
    end
    for (i = 1; i < 8; i = i + 1) rd_word(i, wval[i], "stored word");
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    chk({31'h0, STATUS_PIN_OE}, {31'h0, wval[1][3]}, "pin drive follows bit 3");
    $display("test random_words done");
    // unmapped and unaligned places refuse and leave word 1 alone
    apb(1'b1, 16'h0024, 32'($random(seed)));
    chk({31'h0, err}, 32'h0000_0001, "unmapped write error");
    apb(1'b0, 16'h0024, 32'h0000_0000);
    chk({rd[31:1], err}, 32'h0000_0001, "unmapped read");
    apb(1'b1, 16'h0006, 32'h0000_FFFF);
    chk({31'h0, err}, 32'h0000_0001, "unaligned write error");
    rd_word(1, wval[1], "word 1 untouched");
    $display("test refusals done");
    // divider settings 1 to 7, tick count over a 256 cycle window; drive bit toggles too
    // a zero divider would toggle the calibration clock every cycle, giving 50 MHz from the 100 MHz reference
    for (d = 1; d < 8; d = d + 1) begin
      apb(1'b1, 16'h0004, {16'h0000, 12'h080, d[0], d[2:0]});
      repeat (16) @(posedge CLK);
      @(negedge CLK);
      chk({31'h0, STATUS_PIN_OE}, {31'h0, d[0]}, "pin drive level");
      ticks = 0;
      highs = 0;
      repeat (256) begin
        @(negedge CLK);
        if (SM_TICK === 1'b1) ticks = ticks + 1;
        if (SM_CLK === 1'b1) highs = highs + 1;
      end
      chk(32'(ticks), 32'(256 >> d), "ticks per window");
      chk(32'(highs), 32'h0000_0080, "divided clock half high");
    end
    $display("test divider done");
    // pin function: lock when select set, readback when clear
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 16'h0000, {29'h0, i[0], 2'b00});
      bit_a = 1'($random(seed));
      bit_b = ~bit_a;
      LOCK_IN <= bit_a;
      READBACK_IN <= bit_b;
      repeat (6) @(posedge CLK);
      @(negedge CLK);
      chk({31'h0, STATUS_PIN_O}, {31'h0, i[0] ? bit_a : bit_b}, "status pin source");
    end
    $display("test pin_function done");
    // required programming values, then a wrong upper field in word 1
    apb(1'b1, 16'h0004, 32'h0000_080C);
    apb(1'b1, 16'h0008, 32'h0000_0500);
    apb(1'b1, 16'h000C, 32'h0000_0642);
    apb(1'b1, 16'h001C, 32'h0000_00B2);
    apb(1'b1, 16'h0010, 32'h0000_0E43);
    apb(1'b1, 16'h0014, 32'h0000_03E8);
    apb(1'b1, 16'h0018, 32'h0000_7802);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk({31'h0, RSV_PROGRAMMED}, 32'h0000_0001, "programmed flag set");
    apb(1'b1, 16'h0004, 32'h0000_081C);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk({31'h0, RSV_PROGRAMMED}, 32'h0000_0000, "wrong upper field");
    $display("test required_values done");
    // soft reset restores defaults, refuses writes, stops the tick
    apb(1'b1, 16'h0000, 32'h0000_0002);
    apb(1'b1, 16'h0010, 32'h0000_1234);
    rd_word(4, 16'h0A43, "write refused in soft reset");
    ticks = 0;
    repeat (32) begin
      @(negedge CLK);
      if (SM_TICK !== 1'b0) ticks = ticks + 1;
    end
    chk(32'(ticks), 32'h0000_0000, "tick held in soft reset");
    apb(1'b1, 16'h0000, 32'h0000_0000);
    for (i = 1; i < 8; i = i + 1) rd_word(i, dflt(i), "default after soft reset");
    apb(1'b1, 16'h0010, 32'h0000_0E43);
    rd_word(4, 16'h0E43, "write after release");
    $display("test soft_reset done");
    tally_and_finish();
  end
endmodule
